// ==== logic/pcv_pkg.sv ====
// Constants, field positions and carrier types for the capability register bank.
// Assumes an APB slave with 32-bit data and word-aligned byte addresses.
// Overview of operation
// (R1) Four write-one-to-clear error flags, bits 16-19
// (R2) Aux power detected reads one
// (R3) Bit 21 follows pending transaction input
// (R4) Max link speed code 0001 read-only
// (R5) Max link width one-hot, default single lane; the bank also accepts code 0Ch (x12)
// (R6) ASPM support field read-only 11:10
// (R7) Exit latencies read-only, L0s 3h, L1 0h
// (R8) ASPM control field writable, reset 00
// (R9) Disable/retrain bits read zero in forward mode
// (R10) Common clock and ext sync writable, rest zero
// (R11) Negotiated speed and width from link inputs
// (R12) Train error, training, slot clock one
// (R13) Slot capability bits only with hot-plug reverse
// (R14) Slot control fields writable, reset zero
// (R15) Slot status bits read-only from inputs
// (R16) Five physical-layer control bits writable
// (R17) Retry count 3h and TS1 count 10h
// (R18) L1 entry timer writable, reset 0400h
// (R19) L0s and L1 lifetime timers writable
// (R20) Recovery and exit latencies writable with defaults
// (R21) Product data ID 03h, next F0h
// (R22) Write flag zero starts EEPROM read
// (R23) Write flag one starts EEPROM write
// (R24) EEPROM byte address is address plus 0x40
// (R25) Reserved bits read zero, writes ignored
package pcv_pkg;
  localparam logic [7:0] OFF_DEV_STATUS = 8'hb8;
  localparam logic [7:0] OFF_LINK_CAP   = 8'hbc;
  localparam logic [7:0] OFF_LINK_CTL   = 8'hc0;
  localparam logic [7:0] OFF_SLOT_CAP   = 8'hc4;
  localparam logic [7:0] OFF_SLOT_CTL   = 8'hc8;
  localparam logic [7:0] OFF_PHY0       = 8'hcc;
  localparam logic [7:0] OFF_PHY1       = 8'hd0;
  localparam logic [7:0] OFF_PHY2       = 8'hd4;
  localparam logic [7:0] OFF_PDATA      = 8'hd8;

  localparam logic [3:0]  SPEED_2G5      = 4'h1;
  localparam logic [5:0]  WIDTH_X1       = 6'h01;
  localparam logic [1:0]  ASPM_SUP_RST   = 2'h0;
  localparam logic [2:0]  L0S_EXIT_LAT   = 3'h3;
  localparam logic [2:0]  L1_EXIT_LAT    = 3'h0;
  localparam logic [2:0]  RETRY_RST      = 3'h3;
  localparam logic [4:0]  TS1_RST        = 5'h10;
  localparam logic [15:0] L1_ENTRY_RST   = 16'h0400;
  localparam logic [7:0]  CDR_RST        = 8'h54;
  localparam logic [6:0]  L0S_L0_RST     = 7'h02;
  localparam logic [6:0]  L1_L0_RST      = 7'h19;
  localparam logic [7:0]  PDATA_CAP_ID   = 8'h03;
  localparam logic [7:0]  PDATA_NEXT     = 8'hf0;
  localparam logic [6:0]  EE_BASE        = 7'h40;

  // Reset words built from the fields above, and writable-bit masks as literals
  localparam logic [11:0] LINK_RST       = {2'b00, WIDTH_X1, SPEED_2G5};
  localparam logic [31:0] PHY0_RST       = {L1_ENTRY_RST, 3'h0, TS1_RST, RETRY_RST, 5'h00};
  localparam logic [31:0] PHY1_RST       = 32'h00000000;
  localparam logic [31:0] PHY2_RST       = {9'h000, L1_L0_RST, 1'b0, L0S_L0_RST, CDR_RST};
  localparam logic [31:0] PHY0_MASK      = 32'hffff1fff;
  localparam logic [31:0] PHY1_MASK      = 32'hffff03ff;
  localparam logic [31:0] PHY2_MASK      = 32'h007f7fff;

  // Request to the EEPROM engine outside this bank
  typedef struct packed {
    logic       start;
    logic       write;
    logic [6:0] addr;
  } pcv_ee_req_type;

  // Live link state driven by the physical layer
  typedef struct packed {
    logic [3:0] speed;
    logic [5:0] width;
    logic       train_err;
    logic       training;
  } pcv_link_type;
endpackage : pcv_pkg

// ==== logic/pcv_regs.sv ====
// Capability register bank: device, link, slot, tuning and product data control.
// Assumes a single 50 MHz clock domain; link and slot status inputs arrive from
// other clock domains or pins and are synchronised here; EEPROM engine is same-clock.
module pcv_regs #(
  parameter logic [5:0] MAX_WIDTH = 6'h01,
  parameter logic [1:0] ASPM_SUP  = 2'h0
) (
  input  wire logic                    ref_clk,
  input  wire logic                    reset,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output logic [31:0]                  prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic                    reverse_mode,
  input  wire logic                    hotplug_strap,
  input  wire logic [3:0]              err_event,
  input  wire logic                    txn_pending,
  input  wire pcv_pkg::pcv_link_type   link_in,
  input  wire logic [6:0]              slot_in,
  output pcv_pkg::pcv_ee_req_type      ee_req,
  input  wire logic                    ee_done,
  output logic [10:0]                  slot_ctl_out,
  output logic [31:0]                  phy0_out,
  output logic [31:0]                  phy1_out,
  output logic [31:0]                  phy2_out,
  output logic [1:0]                   aspm_ctl_out
);
  // Width codes the capability field can carry; anything else is reserved
  function automatic logic pcv_width_ok(input logic [5:0] code);
    case (code)
      6'h01, 6'h02, 6'h04, 6'h08, 6'h0c, 6'h10, 6'h20: pcv_width_ok = 1'b1;
      default: pcv_width_ok = 1'b0;
    endcase
  endfunction : pcv_width_ok

  // Word select shared by the read mux and every write strobe
  function automatic logic pcv_hit(input logic [7:0] addr, input logic [7:0] offset);
    pcv_hit = (addr == offset);
  endfunction : pcv_hit

  // Refuse reserved codes at elaboration rather than report nonsense to software
  if (!pcv_width_ok(MAX_WIDTH)) begin : g_bad_width
    $error("MAX_WIDTH code reserved");
  end
  if (ASPM_SUP == 2'h2) begin : g_bad_aspm
    $error("ASPM_SUP code reserved");
  end

  typedef enum logic [1:0] {EE_IDLE = 2'b00, EE_BUSY = 2'b01} pcv_ee_state_type;

  logic [3:0]  err_reg;
  logic        pend_s1_reg, pend_reg;
  logic [11:0] link_s1_reg, link_s2_reg, link_s3_reg, link_reg;
  logic [6:0]  slot_s1_reg, slot_reg;
  logic [1:0]  aspm_reg;
  logic [1:0]  dis_rt_reg;
  logic [1:0]  ccsync_reg;
  logic [10:0] slot_ctl_reg;
  logic [31:0] phy0_reg, phy1_reg, phy2_reg;
  logic [5:0]  ee_addr_reg;
  logic        ee_flag_reg;
  logic        ee_start_reg;
  logic        ee_wr_reg;
  logic        strap_s1_reg;
  logic        strap_reg;
  logic [6:0]  ee_eaddr_reg;
  logic        access_reg;
  logic [31:0] prdata_reg;
  pcv_ee_state_type ee_state_reg;

  // Decode of the access phase and word select
  wire         setup   = psel && !penable;
  wire         wr_acc  = psel && penable && pwrite && access_reg;
  wire         rd_take = setup && !pwrite;
  wire         hp_on   = strap_reg && reverse_mode;

  wire sel_dev  = pcv_hit(paddr, pcv_pkg::OFF_DEV_STATUS);
  wire sel_lcap = pcv_hit(paddr, pcv_pkg::OFF_LINK_CAP);
  wire sel_lctl = pcv_hit(paddr, pcv_pkg::OFF_LINK_CTL);
  wire sel_scap = pcv_hit(paddr, pcv_pkg::OFF_SLOT_CAP);
  wire sel_sctl = pcv_hit(paddr, pcv_pkg::OFF_SLOT_CTL);
  wire sel_p0   = pcv_hit(paddr, pcv_pkg::OFF_PHY0);
  wire sel_p1   = pcv_hit(paddr, pcv_pkg::OFF_PHY1);
  wire sel_p2   = pcv_hit(paddr, pcv_pkg::OFF_PHY2);
  wire sel_pd   = pcv_hit(paddr, pcv_pkg::OFF_PDATA);
  wire mapped   = sel_dev | sel_lcap | sel_lctl | sel_scap | sel_sctl |
                  sel_p0 | sel_p1 | sel_p2 | sel_pd;

  // Write strobes, one per writable word, valid only in the access phase
  wire wr_dev   = wr_acc && sel_dev;
  wire wr_lctl  = wr_acc && sel_lctl;
  wire wr_sctl  = wr_acc && sel_sctl;
  wire wr_p0    = wr_acc && sel_p0;
  wire wr_p1    = wr_acc && sel_p1;
  wire wr_p2    = wr_acc && sel_p2;
  wire wr_pd    = wr_acc && sel_pd;

  // Read words; reserved positions are constant zero
  wire [31:0] dev_word  = {10'h000, pend_reg, 1'b1, err_reg, 16'h0000}; // R2 R3 R25
  wire [31:0] lcap_word = {14'h0000, pcv_pkg::L1_EXIT_LAT, pcv_pkg::L0S_EXIT_LAT,
                           ASPM_SUP, MAX_WIDTH, pcv_pkg::SPEED_2G5}; // R4 R5 R6 R7
  wire [31:0] lctl_word = {3'h0, 1'b1, link_reg, 8'h00, ccsync_reg,
                           reverse_mode ? dis_rt_reg : 2'b00, 2'b00, aspm_reg}; // R9 R10 R11 R12
  wire [31:0] scap_word = {25'h0000000, hp_on, 1'b0, {3{hp_on}}, 1'b0, hp_on}; // R13
  wire [31:0] sctl_word = {9'h000, slot_reg, 5'h00, slot_ctl_reg}; // R15
  wire [31:0] pd_word   = {ee_flag_reg, 7'h00, ee_addr_reg, 2'b00,
                           pcv_pkg::PDATA_NEXT, pcv_pkg::PDATA_CAP_ID}; // R21
  wire [31:0] rd_mux    = sel_dev  ? dev_word  :
                          sel_lcap ? lcap_word :
                          sel_lctl ? lctl_word :
                          sel_scap ? scap_word :
                          sel_sctl ? sctl_word :
                          sel_p0   ? phy0_reg  :
                          sel_p1   ? phy1_reg  :
                          sel_p2   ? phy2_reg  :
                          sel_pd   ? pd_word   : 32'h00000000;

  // No wait state: setup, then access with pready already high
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      access_reg <= 1'b0;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      prdata_reg <= 32'h00000000;
    end else begin
      access_reg <= setup;
      pready     <= setup;
      pslverr    <= setup && !mapped;
      if (rd_take) prdata_reg <= rd_mux;
    end
  end
  assign prdata = prdata_reg;

  // Transaction-pending pin: two flops, so bit 21 lags the pin by two clocks
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pend_s1_reg <= 1'b0;
      pend_reg    <= 1'b0;
    end else begin
      pend_s1_reg <= txn_pending;
      pend_reg    <= pend_s1_reg; // R3
    end
  end

  // Link state: two flops to synchronise, a third to compare against
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      link_s1_reg <= pcv_pkg::LINK_RST;
      link_s2_reg <= pcv_pkg::LINK_RST;
      link_s3_reg <= pcv_pkg::LINK_RST;
    end else begin
      link_s1_reg <= {link_in.training, link_in.train_err, link_in.width, link_in.speed};
      link_s2_reg <= link_s1_reg;
      link_s3_reg <= link_s2_reg;
    end
  end

  // Bits cross one by one, so the word is taken only once it stood for two clocks;
  // software never sees a half-changed speed or width, at two extra clocks of lag
  wire link_steady = (link_s2_reg == link_s3_reg);
  always_ff @(posedge ref_clk) begin
    if (reset) link_reg <= pcv_pkg::LINK_RST;
    else if (link_steady) link_reg <= link_s3_reg; // R11 R12
  end

  // Slot status pins; each bit stands alone, so plain two-flop synchronisers do
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      slot_s1_reg <= 7'h00;
      slot_reg    <= 7'h00;
    end else begin
      slot_s1_reg <= slot_in;
      slot_reg    <= slot_s1_reg; // R15
    end
  end

  // Hot-plug strap is a pin like any other and gets the same two flops
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      strap_s1_reg <= 1'b0;
      strap_reg    <= 1'b0;
    end else begin
      strap_s1_reg <= hotplug_strap;
      strap_reg    <= strap_s1_reg; // R13
    end
  end

  // Error flags: a new event wins over a same-cycle clear
  wire [3:0] err_clr  = wr_dev ? pwdata[19:16] : 4'h0;
  wire [3:0] err_next = (err_reg & ~err_clr) | err_event;
  always_ff @(posedge ref_clk) begin
    if (reset) err_reg <= 4'h0;
    else err_reg <= err_next; // R1
  end

  // Power management entry control, always writable
  always_ff @(posedge ref_clk) begin
    if (reset) aspm_reg <= 2'b00;
    else if (wr_lctl) aspm_reg <= pwdata[1:0]; // R8
  end

  // Common clock and extended sync, always writable
  always_ff @(posedge ref_clk) begin
    if (reset) ccsync_reg <= 2'b00;
    else if (wr_lctl) ccsync_reg <= pwdata[7:6]; // R10
  end

  // Disable and retrain take writes only in reverse mode; a forward bridge drops them
  always_ff @(posedge ref_clk) begin
    if (reset) dis_rt_reg <= 2'b00;
    else if (wr_lctl && reverse_mode) dis_rt_reg <= pwdata[5:4]; // R9
  end

  // Slot event enables and indicator controls
  always_ff @(posedge ref_clk) begin
    if (reset) slot_ctl_reg <= 11'h000;
    else if (wr_sctl) slot_ctl_reg <= pwdata[10:0]; // R14
  end

  // First tuning word: controls, retry and TS1 counts, L1 entry timer
  always_ff @(posedge ref_clk) begin
    if (reset) phy0_reg <= pcv_pkg::PHY0_RST;
    else if (wr_p0) phy0_reg <= pwdata & pcv_pkg::PHY0_MASK; // R16 R17 R18 R25
  end

  // Second tuning word: lifetime timers
  always_ff @(posedge ref_clk) begin
    if (reset) phy1_reg <= pcv_pkg::PHY1_RST;
    else if (wr_p1) phy1_reg <= pwdata & pcv_pkg::PHY1_MASK; // R19 R25
  end

  // Third tuning word: recovery time and exit latencies
  always_ff @(posedge ref_clk) begin
    if (reset) phy2_reg <= pcv_pkg::PHY2_RST;
    else if (wr_p2) phy2_reg <= pwdata & pcv_pkg::PHY2_MASK; // R20 R25
  end

  // EEPROM cycle: flag shows direction until done, then flips
  wire ee_go = wr_pd && (ee_state_reg == EE_IDLE);
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ee_state_reg <= EE_IDLE;
      ee_addr_reg  <= 6'h00;
      ee_eaddr_reg <= pcv_pkg::EE_BASE;
      ee_flag_reg  <= 1'b0;
      ee_wr_reg    <= 1'b0;
      ee_start_reg <= 1'b0;
    end else begin
      ee_start_reg <= ee_go;
      case (ee_state_reg)
        EE_IDLE: begin
          if (ee_go) begin
            ee_addr_reg  <= pwdata[23:18];
            // Offset added here so the request port comes straight from a flop
            ee_eaddr_reg <= {1'b0, pwdata[23:18]} + pcv_pkg::EE_BASE; // R24
            ee_flag_reg  <= pwdata[31]; // R22 R23
            ee_wr_reg    <= pwdata[31];
            ee_state_reg <= EE_BUSY;
          end
        end
        EE_BUSY: begin
          // Writes while busy are dropped; the cycle in flight must finish
          if (ee_done) begin
            ee_flag_reg  <= !ee_wr_reg; // R22 R23
            ee_state_reg <= EE_IDLE;
          end
        end
        default: ee_state_reg <= EE_IDLE;
      endcase
    end
  end

  assign ee_req.start = ee_start_reg;
  assign ee_req.write = ee_wr_reg;
  assign ee_req.addr  = ee_eaddr_reg; // R24
  assign slot_ctl_out = slot_ctl_reg;
  assign phy0_out     = phy0_reg;
  assign phy1_out     = phy1_reg;
  assign phy2_out     = phy2_reg;
  assign aspm_ctl_out = aspm_reg;
endmodule : pcv_regs

// ==== sim/pcv_ee_model.sv ====
// Behavioural EEPROM engine facing the bank's request port.
// Assumes the same clock as the bank; latency is set by the bench.
module pcv_ee_model (
  input  wire logic                    ref_clk,
  input  wire logic                    reset,
  input  wire pcv_pkg::pcv_ee_req_type ee_req,
  input  wire logic [7:0]              lat,
  output logic                         ee_done,
  output logic [6:0]                   seen_addr
);
  logic [7:0] cnt_reg;
  // A long latency lets software catch the flag in mid-cycle
  always_ff @(posedge ref_clk) begin
    ee_done <= 1'b0;
    if (reset) begin
      cnt_reg <= 8'h0;
    end else if (ee_req.start) begin
      cnt_reg   <= lat;
      seen_addr <= ee_req.addr;
    end else if (cnt_reg != 8'h0) begin
      cnt_reg <= cnt_reg - 8'h1;
      ee_done <= (cnt_reg == 8'h1);
    end
  end
endmodule : pcv_ee_model

// ==== sim/pcv_regs_properties.sv ====
// Checker for the capability register bank, bound to its ports.
// Assumes one clock domain and the one-cycle APB answer of the bank.
module pcv_regs_chk (
  input wire logic                    ref_clk,
  input wire logic                    reset,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [7:0]              paddr,
  input wire logic [31:0]             pwdata,
  input wire logic [31:0]             prdata,
  input wire logic                    pready,
  input wire logic                    pslverr,
  input wire pcv_pkg::pcv_ee_req_type ee_req,
  input wire logic                    ee_done,
  input wire logic [10:0]             slot_ctl_out,
  input wire logic [31:0]             phy0_out,
  input wire logic [1:0]              aspm_ctl_out
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // Access decode
  wire acc = psel && penable && pready;
  wire wr  = acc && pwrite;
  wire rd  = acc && !pwrite;
  wire bad = paddr < 8'hb8 || paddr > 8'hd8 || paddr[1:0] != 2'h0;
  logic busy_reg;
  // Engine busy from launch to completion; writes meanwhile must not relaunch
  always_ff @(posedge ref_clk) begin
    if (reset || ee_done) busy_reg <= 1'b0;
    else if (ee_req.start) busy_reg <= 1'b1;
  end
  sequence s_launch;
    wr && paddr == 8'hd8 && !busy_reg;
  endsequence
  a_ee_launch: assert property (s_launch |=> ee_req.start && ee_req.write == $past(pwdata[31]))
    else $error("eeprom launch wrong");
  a_ee_address: assert property (s_launch |=> ee_req.addr == {1'b0, $past(pwdata[23:18])} + 7'h40)
    else $error("eeprom address wrong");
  a_ee_single: assert property (ee_req.start |=> !ee_req.start [*2])
    else $error("eeprom start not a pulse");
  a_unmapped_err: assert property (acc && bad |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (acc && !bad |-> !pslverr)
    else $error("mapped access refused");
  a_aspm_write: assert property (wr && paddr == 8'hc0 |=> aspm_ctl_out == $past(pwdata[1:0]))
    else $error("aspm control not written");
  a_phy0_write: assert property (wr && paddr == 8'hcc |=> phy0_out == ($past(pwdata) & 32'hffff1fff))
    else $error("tuning word not written");
  a_slot_write: assert property (wr && paddr == 8'hc8 |=> slot_ctl_out == $past(pwdata[10:0]))
    else $error("slot control not written");
  a_ids_read: assert property (rd && paddr == 8'hd8 |-> prdata[15:0] == 16'hf003 && prdata[30:24] == 7'h0)
    else $error("product data ids wrong");
  a_aux_read: assert property (rd && paddr == 8'hb8 |-> prdata[20] && prdata[31:22] == 10'h0)
    else $error("aux power bit wrong");
endmodule : pcv_regs_chk

bind pcv_regs pcv_regs_chk u_chk (.ref_clk(ref_clk), .reset(reset), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .ee_req(ee_req), .ee_done(ee_done),
  .slot_ctl_out(slot_ctl_out), .phy0_out(phy0_out), .aspm_ctl_out(aspm_ctl_out));

// ==== sim/tb.sv ====
// Self-checking bench for the capability register bank.
// Assumes 50 MHz clock and an APB slave answering within a few cycles.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic        w;
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] x;
  } pcv_row_type;
  logic ref_clk, reset, psel, penable, pwrite, pready, pslverr, e;
  logic reverse_mode, hotplug_strap, txn_pending, ee_done;
  logic [7:0]  paddr, lat;
  logic [31:0] pwdata, prdata, q, phy1_o, phy2_o;
  logic [3:0]  err_event;
  logic [6:0]  slot_in, seen_addr;
  pcv_pkg::pcv_link_type   link_in;
  pcv_pkg::pcv_ee_req_type ee_req;
  int mismatches, compares;
  pcv_row_type rows [15] = '{
    '{1'b0, 8'hcc, 32'h0, 32'h04001060}, '{1'b0, 8'hd4, 32'h0, 32'h00190254},
    '{1'b0, 8'hd0, 32'h0, 32'h0}, '{1'b0, 8'hc8, 32'h0, 32'h0},
    '{1'b0, 8'hc0, 32'h0, 32'h10110000}, '{1'b0, 8'hbc, 32'h0, 32'h00003011},
    '{1'b0, 8'hb8, 32'h0, 32'h00100000}, '{1'b0, 8'hc4, 32'h0, 32'h0},
    '{1'b1, 8'hcc, '1, 32'hffff1fff}, '{1'b1, 8'hd0, '1, 32'hffff03ff},
    '{1'b1, 8'hd4, '1, 32'h007f7fff}, '{1'b1, 8'hc8, '1, 32'h000007ff},
    '{1'b1, 8'hc0, '1, 32'h101100c3}, '{1'b1, 8'hbc, '1, 32'h00003011},
    '{1'b1, 8'hc4, '1, 32'h0}};
  always #10 ref_clk = ~ref_clk;
  pcv_regs dut (.ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .reverse_mode(reverse_mode), .hotplug_strap(hotplug_strap),
    .err_event(err_event), .txn_pending(txn_pending), .link_in(link_in), .slot_in(slot_in),
    .ee_req(ee_req), .ee_done(ee_done), .slot_ctl_out(), .phy0_out(), .phy1_out(phy1_o),
    .phy2_out(phy2_o), .aspm_ctl_out());
  pcv_ee_model u_ee (.ref_clk(ref_clk), .reset(reset), .ee_req(ee_req), .lat(lat),
    .ee_done(ee_done), .seen_addr(seen_addr));
  task tally_and_finish;
    $display("mismatches=%0d compares=%0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer; an idle edge follows so back-to-back calls never clash
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      mismatches++;
      $display("unexpected at %0t: no ready from the bank", $time);
      tally_and_finish;
    end
    @(posedge ref_clk);
  endtask : apb
  // Polls the product data flag, bounded
  task wait_flag(input logic v);
    int n;
    n = 0;
    do begin
      apb(1'b0, 8'hd8, 32'h0);
      n++;
    end while (q[31] !== v && n < 100);
    if (n >= 100) begin
      chk({31'h0, q[31]}, {31'h0, v});
      tally_and_finish;
    end
  endtask : wait_flag
  initial begin
    {ref_clk, reset, psel, penable, pwrite, reverse_mode, hotplug_strap, txn_pending} = 8'h40;
    paddr = 8'h0;
    pwdata = 32'h0;
    err_event = 4'h0;
    slot_in = 7'h0;
    lat = 8'h3;
    link_in = '{4'h1, 6'h01, 1'b0, 1'b0};
    mismatches = 0;
    compares = 0;
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].w) apb(1'b1, rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 32'h0);
      chk(q, rows[i].x);
    end
    // Second and third tuning outputs carry the written words to the physical layer
    chk(phy1_o, 32'hffff03ff);
    chk(phy2_o, 32'h007f7fff);
    // Error flags set by events, cleared only by writing one
    err_event <= 4'hf;
    @(posedge ref_clk);
    err_event <= 4'h0;
    apb(1'b0, 8'hb8, 32'h0);
    chk(q, 32'h001f0000);
    apb(1'b1, 8'hb8, 32'h00050000);
    apb(1'b0, 8'hb8, 32'h0);
    chk(q, 32'h001a0000);
    txn_pending <= 1'b1;
    repeat (4) @(posedge ref_clk);
    apb(1'b0, 8'hb8, 32'h0);
    chk(q, 32'h003a0000);
    // Reverse bridge with hot-plug strapped and live link state
    reverse_mode <= 1'b1;
    hotplug_strap <= 1'b1;
    link_in <= '{4'h1, 6'h04, 1'b1, 1'b1};
    slot_in <= 7'h55;
    repeat (4) @(posedge ref_clk);
    apb(1'b0, 8'hc4, 32'h0);
    chk(q, 32'h0000005d);
    apb(1'b1, 8'hc0, 32'h00000030);
    apb(1'b0, 8'hc0, 32'h0);
    chk(q, 32'h1c410030);
    apb(1'b0, 8'hc8, 32'h0);
    chk(q, 32'h005507ff);
    hotplug_strap <= 1'b0;
    repeat (3) @(posedge ref_clk);
    apb(1'b0, 8'hc4, 32'h0);
    chk(q, 32'h0);
    apb(1'b0, 8'hb4, 32'h0);
    chk({31'h0, e}, 32'h1);
    // EEPROM read, then a slow write with a refused write in between
    apb(1'b1, 8'hd8, 32'h00140000);
    wait_flag(1'b1);
    chk(q, 32'h8014f003);
    chk({25'h0, seen_addr}, 32'h45);
    lat <= 8'h40;
    apb(1'b1, 8'hd8, 32'h80280000);
    apb(1'b1, 8'hd8, 32'h003c0000);
    apb(1'b0, 8'hd8, 32'h0);
    chk(q, 32'h8028f003);
    wait_flag(1'b0);
    chk(q, 32'h0028f003);
    chk({25'h0, seen_addr}, 32'h4a);
    // Mid-run reset returns written fields and outputs to their defaults
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    chk(phy2_o, 32'h00190254);
    apb(1'b0, 8'hd8, 32'h0);
    chk(q, 32'h0000f003);
    apb(1'b0, 8'hcc, 32'h0);
    chk(q, 32'h04001060);
    tally_and_finish;
  end
endmodule : tb
